// file: logic/pes_event_select.sv
// Event selection and counting for the core's two performance counters.
// Assumes clk is the core's gated clock and all event inputs are on that clock.
//
// Contract
// - Counter 1 event 35 counts completed coprocessor-two transfers, loads and stores.
// - Counter 1 event 19 counts failed store_conditional instructions.
// - Counter 0 event 23 counts every exception taken.
// - Counter 0 event 49 counts debug instruction-breakpoint matches.
// - Counter 1 event 49 counts debug data-breakpoint matches.
// - Counter 1 event 25 counts cycles the ALU pipeline cannot advance.
// - Counter 0 event 18 counts issue-stall cycles once, whatever the causes.
// - Simultaneous specific stalls increment every counter selecting any of them.
// - Specific stall events include bubbles from replays inside the pipe.
// - Counter 0 event 40 counts uncached fetch, load or store stall cycles.
// - Counter 0 event 41 counts cycles waiting on multiply_divide_unit results.
// - Counter 0 event 42 counts cycles waiting on coprocessor_two return data.
// - Counter 1 event 42 counts cycles waiting on extension-unit return data.
// - Counter 0 event 45 counts load-to-use interlock cycles.
// - Counter 0 event 46 counts sysctl_move_from and hw_register_read wait cycles.
// - Counter 1 event 28 is constant one when coprocessor two exists.
// - Counter 0 event 30 is constant one when the extension unit exists.
// - Counters run on the gated clock and stop while it is stopped.
// - After reset no counter counts until software enables it.
// - Each counter is a 32-bit value software can read and write.
`include "pes_params.svh"

module pes_event_select #(
    parameter bit cop2_present = 1'b1,
    parameter bit udi_present = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [`PES_NCTR-1:0] ctl_write,
    input wire logic [`PES_NCTR-1:0] ctl_enable_in,
    input wire logic [`PES_NCTR-1:0][`PES_EV_W-1:0] ctl_event_in,
    input wire logic [`PES_NCTR-1:0] cnt_write,
    input wire logic [`PES_NCTR-1:0][`PES_CNT_W-1:0] cnt_wdata,
    input wire logic coprocessor_two_xfer_done,
    input wire logic store_conditional_fail,
    input wire logic exception_taken,
    input wire logic ibrk_match,
    input wire logic dbrk_match,
    input wire logic alu_stall,
    input wire logic register_fetch_stage_stall,
    input wire logic uncached_stall,
    input wire logic multiply_divide_unit_stall,
    input wire logic coprocessor_two_stall,
    input wire logic udi_stall,
    input wire logic load_use_stall,
    input wire logic interlock_stall,
    output logic [`PES_NCTR-1:0] ctl_enable,
    output logic [`PES_NCTR-1:0][`PES_EV_W-1:0] ctl_event,
    output logic [`PES_NCTR-1:0][`PES_CNT_W-1:0] count
);

    // ==========================================================
    // Event decode
    // Used once per counter; the counter index picks the event column.
    function automatic logic evt_hit(
        input logic ctr,
        input logic [`PES_EV_W-1:0] ev,
        input pes_pkg::pes_evt_s e
    );
        logic hit;
        hit = 1'b0;
        if (!ctr) begin
            case (ev)
                `PES_EV_EXC: hit = e.exc;
                `PES_EV_TRIGGER: hit = e.ibrk;
                // Issue stall already includes the ALU stall, so OR keeps it single
                `PES_EV_STALL_ANY: hit = e.rf_stall | e.alu_stall;
                `PES_EV_UNCACHED: hit = e.uncached;
                `PES_EV_MDU_STALL: hit = e.mdu_stall;
                `PES_EV_EXT_STALL: hit = e.cop2_stall;
                `PES_EV_LOAD_USE: hit = e.load_use;
                `PES_EV_INTERLOCK: hit = e.interlock;
                `PES_EV_UDI_PRESENT: hit = udi_present;
                default: hit = 1'b0;
            endcase
        end else begin
            case (ev)
                `PES_EV_COP2_XFER: hit = e.cop2_xfer;
                `PES_EV_SC_FAIL: hit = e.sc_fail;
                `PES_EV_TRIGGER: hit = e.dbrk;
                `PES_EV_ALU_STALL: hit = e.alu_stall;
                `PES_EV_EXT_STALL: hit = e.udi_stall;
                `PES_EV_COP2_PRESENT: hit = cop2_present;
                default: hit = 1'b0;
            endcase
        end
        return hit;
    endfunction

    // ==========================================================
    // State
    pes_pkg::pes_state_s state;
    pes_pkg::pes_state_s next_state;
    pes_pkg::pes_evt_s evt;
    logic [`PES_NCTR-1:0] hit;

    assign evt = '{
        cop2_xfer: coprocessor_two_xfer_done,
        sc_fail: store_conditional_fail,
        exc: exception_taken,
        ibrk: ibrk_match,
        dbrk: dbrk_match,
        alu_stall: alu_stall,
        rf_stall: register_fetch_stage_stall,
        uncached: uncached_stall,
        mdu_stall: multiply_divide_unit_stall,
        cop2_stall: coprocessor_two_stall,
        udi_stall: udi_stall,
        load_use: load_use_stall,
        interlock: interlock_stall
    };

    // Each counter decodes independently, so simultaneous stall sources
    // reach every counter selecting one of them.
    always_comb begin
        next_state = state;
        for (int i = 0; i < `PES_NCTR; i++) begin
            hit[i] = evt_hit(i[0], state.ev[i], evt);
            if (ctl_write[i]) begin
                next_state.en[i] = ctl_enable_in[i];
                next_state.ev[i] = ctl_event_in[i];
            end
            // A software write wins over a same-cycle increment
            if (cnt_write[i]) begin
                next_state.cnt[i] = cnt_wdata[i];
            end else if (state.en[i] && hit[i]) begin
                next_state.cnt[i] = state.cnt[i] + `PES_CNT_ONE;
            end
        end
    end

    // No enable term: with the gated clock stopped nothing advances
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state.en <= '0;
            state.ev <= {`PES_NCTR{`PES_EV_RST}};
            state.cnt <= {`PES_NCTR{`PES_CNT_RST}};
        end else begin
            state <= next_state;
        end
    end

    assign ctl_enable = state.en;
    assign ctl_event = state.ev;
    assign count = state.cnt;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_ctr0_sel(logic [`PES_EV_W-1:0] ev);
        state.en[0] && state.ev[0] == ev && !cnt_write[0];
    endsequence

    sequence s_ctr1_sel(logic [`PES_EV_W-1:0] ev);
        state.en[1] && state.ev[1] == ev && !cnt_write[1];
    endsequence

    exc_count_a: assert property (
        s_ctr0_sel(`PES_EV_EXC) and exception_taken |=>
            count[0] == $past(count[0]) + `PES_CNT_ONE)
        else $error("exception not counted");

    stall_once_a: assert property (
        s_ctr0_sel(`PES_EV_STALL_ANY) and alu_stall and register_fetch_stage_stall |=>
            count[0] == $past(count[0]) + `PES_CNT_ONE)
        else $error("stall cycle not counted once");

    sc_fail_a: assert property (
        s_ctr1_sel(`PES_EV_SC_FAIL) and !store_conditional_fail |=>
            $stable(count[1]))
        else $error("store conditional count moved without failure");

    multi_stall_a: assert property (
        s_ctr0_sel(`PES_EV_MDU_STALL) and s_ctr1_sel(`PES_EV_ALU_STALL)
            and multiply_divide_unit_stall and alu_stall |=>
            count[0] == $past(count[0]) + `PES_CNT_ONE
            && count[1] == $past(count[1]) + `PES_CNT_ONE)
        else $error("simultaneous stalls not all counted");

    cop2_const_a: assert property (
        s_ctr1_sel(`PES_EV_COP2_PRESENT) [*3] |=>
            count[1] == $past(count[1], 3) + (cop2_present ? 32'h3 : 32'h0))
        else $error("coprocessor presence event wrong");

    trig_split_a: assert property (
        s_ctr0_sel(`PES_EV_TRIGGER) and s_ctr1_sel(`PES_EV_TRIGGER)
            and ibrk_match and !dbrk_match |=>
            count[0] == $past(count[0]) + `PES_CNT_ONE && $stable(count[1]))
        else $error("breakpoint matches routed to wrong counter");

    disabled_a: assert property (
        !state.en[0] && !cnt_write[0] |=> $stable(count[0]))
        else $error("disabled counter advanced");

    sw_write_a: assert property (
        cnt_write[1] |=> count[1] == $past(cnt_wdata[1]))
        else $error("counter write lost");

    // One enabled load-to-use wait cycle on counter 0; grouped so that the
    // stall level is demanded in both cycles, not only the first
    sequence s_lu_wait;
        s_ctr0_sel(`PES_EV_LOAD_USE) and load_use_stall;
    endsequence

    load_use_a: assert property (
        s_lu_wait ##1 s_lu_wait |=>
            count[0] == $past(count[0], 2) + 32'h2)
        else $error("load-to-use cycles miscounted");

    udi_wait_a: assert property (
        s_ctr1_sel(`PES_EV_EXT_STALL) and udi_stall and !coprocessor_two_stall |=>
            count[1] == $past(count[1]) + `PES_CNT_ONE)
        else $error("extension unit stall not counted");

    // ==========================================================
    // Per-event, disable, write and control checks
    exc_idle_a: assert property (
        s_ctr0_sel(`PES_EV_EXC) and !exception_taken |=> $stable(count[0]))
        else $error("exception count moved without an exception");

    cop2_xfer_a: assert property (
        s_ctr1_sel(`PES_EV_COP2_XFER) and coprocessor_two_xfer_done |=>
            count[1] == $past(count[1]) + `PES_CNT_ONE)
        else $error("coprocessor transfer not counted");

    xfer_idle_a: assert property (
        s_ctr1_sel(`PES_EV_COP2_XFER) and !coprocessor_two_xfer_done |=>
            $stable(count[1]))
        else $error("transfer count moved without a transfer");

    ibrk_idle_a: assert property (
        s_ctr0_sel(`PES_EV_TRIGGER) and !ibrk_match |=> $stable(count[0]))
        else $error("instruction breakpoint count moved without a match");

    dbrk_count_a: assert property (
        s_ctr1_sel(`PES_EV_TRIGGER) and dbrk_match |=>
            count[1] == $past(count[1]) + `PES_CNT_ONE)
        else $error("data breakpoint match not counted");

    alu_stall_a: assert property (
        s_ctr1_sel(`PES_EV_ALU_STALL) and alu_stall |=>
            count[1] == $past(count[1]) + `PES_CNT_ONE)
        else $error("alu stall cycle not counted");

    stall_rf_a: assert property (
        s_ctr0_sel(`PES_EV_STALL_ANY) and register_fetch_stage_stall and !alu_stall |=>
            count[0] == $past(count[0]) + `PES_CNT_ONE)
        else $error("issue stall cycle not counted");

    stall_idle_a: assert property (
        s_ctr0_sel(`PES_EV_STALL_ANY) and !register_fetch_stage_stall
            and !alu_stall |=>
            $stable(count[0]))
        else $error("stall count moved without a stall");

    uncached_a: assert property (
        s_ctr0_sel(`PES_EV_UNCACHED) and uncached_stall |=>
            count[0] == $past(count[0]) + `PES_CNT_ONE)
        else $error("uncached stall cycle not counted");

    mdu_wait_a: assert property (
        s_ctr0_sel(`PES_EV_MDU_STALL) and multiply_divide_unit_stall |=>
            count[0] == $past(count[0]) + `PES_CNT_ONE)
        else $error("multiply divide wait not counted");

    cop2_wait_a: assert property (
        s_ctr0_sel(`PES_EV_EXT_STALL) and coprocessor_two_stall |=>
            count[0] == $past(count[0]) + `PES_CNT_ONE)
        else $error("coprocessor wait not counted");

    interlock_a: assert property (
        s_ctr0_sel(`PES_EV_INTERLOCK) and interlock_stall |=>
            count[0] == $past(count[0]) + `PES_CNT_ONE)
        else $error("interlock wait not counted");

    udi_const_a: assert property (
        s_ctr0_sel(`PES_EV_UDI_PRESENT) |=>
            count[0] == $past(count[0]) + (udi_present ? `PES_CNT_ONE : `PES_CNT_RST))
        else $error("extension presence event wrong");

    unmapped_a: assert property (
        s_ctr1_sel(`PES_EV_EXC) |=> $stable(count[1]))
        else $error("counter 1 moved on an event it does not have");

    disabled1_a: assert property (
        !state.en[1] && !cnt_write[1] |=> $stable(count[1]))
        else $error("disabled counter 1 advanced");

    sw_write0_a: assert property (
        cnt_write[0] |=> count[0] == $past(cnt_wdata[0]))
        else $error("counter 0 write lost");

    ctl_load0_a: assert property (
        ctl_write[0] |=> ctl_event[0] == $past(ctl_event_in[0])
            && ctl_enable[0] == $past(ctl_enable_in[0]))
        else $error("counter 0 control write lost");

    ctl_load1_a: assert property (
        ctl_write[1] |=> ctl_event[1] == $past(ctl_event_in[1])
            && ctl_enable[1] == $past(ctl_enable_in[1]))
        else $error("counter 1 control write lost");

endmodule

// file: logic/pes_params.svh
// Constants for the performance event selector.
// Assumes inclusion by logic/pes_pkg.sv and logic/pes_event_select.sv.
`ifndef PES_PARAMS_SVH
`define PES_PARAMS_SVH

// ==========================================================
// Widths and reset values
`define PES_CNT_W 32
`define PES_EV_W 6
`define PES_NCTR 2
`define PES_CNT_RST 32'h0000_0000
`define PES_CNT_ONE 32'h0000_0001
`define PES_EV_RST 6'h00

// ==========================================================
// Event numbers
`define PES_EV_STALL_ANY 6'h12
`define PES_EV_SC_FAIL 6'h13
`define PES_EV_EXC 6'h17
`define PES_EV_ALU_STALL 6'h19
`define PES_EV_COP2_PRESENT 6'h1c
`define PES_EV_UDI_PRESENT 6'h1e
`define PES_EV_COP2_XFER 6'h23
`define PES_EV_UNCACHED 6'h28
`define PES_EV_MDU_STALL 6'h29
`define PES_EV_EXT_STALL 6'h2a
`define PES_EV_LOAD_USE 6'h2d
`define PES_EV_INTERLOCK 6'h2e
`define PES_EV_TRIGGER 6'h31

`endif

// file: logic/pes_pkg.sv
// Types shared by the performance event selector.
// Assumes pes_params.svh is on the include path.
`include "pes_params.svh"

package pes_pkg;

    // ==========================================================
    // Per-cycle event conditions from the pipeline
    typedef struct packed {
        logic cop2_xfer;
        logic sc_fail;
        logic exc;
        logic ibrk;
        logic dbrk;
        logic alu_stall;
        logic rf_stall;
        logic uncached;
        logic mdu_stall;
        logic cop2_stall;
        logic udi_stall;
        logic load_use;
        logic interlock;
    } pes_evt_s;

    // ==========================================================
    // Whole block state
    typedef struct packed {
        logic [`PES_NCTR-1:0] en;
        logic [`PES_NCTR-1:0][`PES_EV_W-1:0] ev;
        logic [`PES_NCTR-1:0][`PES_CNT_W-1:0] cnt;
    } pes_state_s;

endpackage

// file: verif/pes_tb.sv
// Self-checking bench for the performance event selector.
// Assumes the default parameters: coprocessor two present, extension unit absent.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] ctl_write = 2'h0;
    logic [1:0] ctl_enable_in = 2'h0;
    logic [1:0][5:0] ctl_event_in = '0;
    logic [1:0] cnt_write = 2'h0;
    logic [1:0][31:0] cnt_wdata = '0;
    // Bit order: xfer sc exc ibrk dbrk alu rf uncached mdu cop2 udi load_use interlock
    logic [12:0] ev_in = 13'h0000;
    logic [1:0] ctl_enable;
    logic [1:0][5:0] ctl_event;
    logic [1:0][31:0] count;
    int errors = 0;
    int n_compared = 0;
    logic [5:0] t0 [7] = '{6'h17, 6'h31, 6'h28, 6'h29, 6'h2a, 6'h2d, 6'h2e};
    logic [5:0] t1 [7] = '{6'h23, 6'h13, 6'h31, 6'h19, 6'h2a, 6'h17, 6'h29};
    logic [12:0] tm [7] = '{13'h1400, 13'h0a00, 13'h0120, 13'h0090, 13'h000c,
                            13'h0002, 13'h0001};
    logic [31:0] tx1 [7] = '{32'h3, 32'h3, 32'h3, 32'h3, 32'h3, 32'h0, 32'h0};

    pes_event_select i_pes_event_select (
        .clk(clk), .reset(reset), .ctl_write(ctl_write), .ctl_enable_in(ctl_enable_in),
        .ctl_event_in(ctl_event_in), .cnt_write(cnt_write), .cnt_wdata(cnt_wdata),
        .coprocessor_two_xfer_done(ev_in[12]), .store_conditional_fail(ev_in[11]),
        .exception_taken(ev_in[10]), .ibrk_match(ev_in[9]), .dbrk_match(ev_in[8]),
        .alu_stall(ev_in[7]), .register_fetch_stage_stall(ev_in[6]),
        .uncached_stall(ev_in[5]), .multiply_divide_unit_stall(ev_in[4]),
        .coprocessor_two_stall(ev_in[3]), .udi_stall(ev_in[2]),
        .load_use_stall(ev_in[1]), .interlock_stall(ev_in[0]),
        .ctl_enable(ctl_enable), .ctl_event(ctl_event), .count(count)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // Program both counters from zero, then hold the events for three cycles
    task automatic measure(input logic [1:0] en, input logic [5:0] e0, input logic [5:0] e1,
                           input logic [12:0] m, input logic [31:0] x0, input logic [31:0] x1);
        @(posedge clk);
        ctl_write <= 2'h3;
        ctl_enable_in <= en;
        ctl_event_in <= {e1, e0};
        cnt_write <= 2'h3;
        cnt_wdata <= '0;
        @(posedge clk);
        ctl_write <= 2'h0;
        cnt_write <= 2'h0;
        ev_in <= m;
        repeat (3) @(posedge clk);
        ev_in <= 13'h0000;
        @(posedge clk);
        #1;
        check(count[0], x0);
        check(count[1], x1);
        check({20'h0, ctl_event}, {20'h0, e1, e0});
        check({30'h0, ctl_enable}, {30'h0, en});
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_after_reset();
        #1;
        check({30'h0, ctl_enable}, 32'h0);
        check(count[0], 32'h0);
        check(count[1], 32'h0);
        check({20'h0, ctl_event}, 32'h0);
        measure(2'h0, 6'h17, 6'h23, 13'h1fff, 32'h0, 32'h0);
    endtask

    task automatic test_event_table();
        for (int i = 0; i < 7; i++) begin
            measure(2'h3, t0[i], t1[i], tm[i], 32'h3, tx1[i]);
            measure(2'h3, t0[i], t1[i], ~tm[i], 32'h0, 32'h0);
        end
        measure(2'h3, 6'h31, 6'h31, 13'h0200, 32'h3, 32'h0);
        measure(2'h3, 6'h31, 6'h31, 13'h0100, 32'h0, 32'h3);
    endtask

    task automatic test_stalls();
        measure(2'h3, 6'h12, 6'h19, 13'h00c0, 32'h3, 32'h3);
        measure(2'h3, 6'h12, 6'h19, 13'h0040, 32'h3, 32'h0);
        measure(2'h3, 6'h29, 6'h19, 13'h0090, 32'h3, 32'h3);
        measure(2'h3, 6'h2d, 6'h2a, 13'h0006, 32'h3, 32'h3);
    endtask

    task automatic test_presence();
        // The coprocessor-two constant event counts every enabled cycle, four of them in a measure
        measure(2'h3, 6'h1e, 6'h1c, 13'h0000, 32'h0, 32'h4);
    endtask

    task automatic test_count_write();
        @(posedge clk);
        ctl_write <= 2'h1;
        ctl_enable_in <= 2'h1;
        ctl_event_in <= {6'h00, 6'h17};
        @(posedge clk);
        ctl_write <= 2'h0;
        cnt_write <= 2'h1;
        cnt_wdata <= {32'h0, 32'hffff_ffff};
        ev_in <= 13'h0400;
        @(posedge clk);
        cnt_write <= 2'h0;
        #1;
        check({26'h0, ctl_event[0]}, 32'h17);
        check(count[0], 32'hffff_ffff);
        @(posedge clk);
        ev_in <= 13'h0000;
        #1;
        check(count[0], 32'h0);
    endtask

    // Reset in mid-run with counters enabled: all must clear and stay still
    task automatic test_reset_again();
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        ev_in <= 13'h1fff;
        repeat (3) @(posedge clk);
        ev_in <= 13'h0000;
        #1;
        check({30'h0, ctl_enable}, 32'h0);
        check(count[0], 32'h0);
        check(count[1], 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        test_after_reset();
        test_event_table();
        test_stalls();
        test_presence();
        test_count_write();
        test_reset_again();
        summarize();
    end

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        summarize();
    end
endmodule
